// *** eeu_external_edge_event_unit.sv ***
// eeu_external_edge_event_unit.sv: edge event unit with register port, pin routing,
// pending record, interrupt and event outputs
// assumes: pins and aux lines are asynchronous; register master runs on ref_clk
`timescale 1ns/1ps
`include "eeu_consts.svh"

module eeu_external_edge_event_unit (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire eeu_pkg::eeu_addr_t reg_addr,
   input  wire eeu_pkg::eeu_word_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output eeu_pkg::eeu_word_t      reg_rdata,
   input  wire eeu_pkg::eeu_pins_t pin_in,
   input  wire eeu_pkg::eeu_aux_t  aux_line_in,
   output logic                   irq,
   output eeu_pkg::eeu_line_t      event_out
);
   import eeu_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   eeu_line_t imask_reg;
   eeu_line_t imask_next;
   eeu_line_t emask_reg;
   eeu_line_t emask_next;
   eeu_line_t rise_reg;
   eeu_line_t rise_next;
   eeu_line_t fall_reg;
   eeu_line_t fall_next;
   eeu_line_t pending_reg;
   eeu_line_t pending_next;
   eeu_sel_t  sel_reg [`EEU_PIN_LINES];
   eeu_word_t rdata_reg;
   eeu_word_t rdata_next;
   logic      irq_reg;
   logic      irq_next;
   eeu_line_t event_out_reg;
   eeu_line_t event_out_next;

   // ----------------------------------------------------------------
   // line sources and edge hits
   // ----------------------------------------------------------------
   eeu_line_t line_src;
   eeu_line_t edge_hit;
   eeu_line_t clr_bits;
   eeu_word_t sel_word [4];

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic imsk_hit;
   logic emsk_hit;
   logic rise_hit;
   logic fall_hit;
   logic pend_hit;
   logic sel_hit;
   logic pend_wr;

   assign imsk_hit = (reg_addr == `EEU_OFF_IMSK);
   assign emsk_hit = (reg_addr == `EEU_OFF_EMSK);
   assign rise_hit = (reg_addr == `EEU_OFF_RISE);
   assign fall_hit = (reg_addr == `EEU_OFF_FALL);
   assign pend_hit = (reg_addr == `EEU_OFF_PEND);
   assign sel_hit  = (reg_addr[7:4] == `EEU_SEL_PAGE) && (reg_addr[1:0] == 2'h0);
   assign pend_wr  = reg_wr && pend_hit;

   // ----------------------------------------------------------------
   // pin routing onto the first sixteen lines
   // ----------------------------------------------------------------
   // a select beyond the last pin parks the line low instead of reading x
   genvar gi;
   generate
      for (gi = 0; gi < `EEU_PIN_LINES; gi++) begin : g_route
         localparam logic [7:0] SEL_ADDR = 8'(`EEU_OFF_SEL0 + 4 * (gi / 4));
         logic sel_wr;
         assign sel_wr = reg_wr && (reg_addr == SEL_ADDR);
         assign line_src[gi] = (sel_reg[gi] < 8'(`EEU_PINS)) ?
                               pin_in[sel_reg[gi]] : 1'b0;
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               sel_reg[gi] <= `EEU_RST_SEL;
            end else if (ce && sel_wr) begin
               sel_reg[gi] <= reg_wdata[8 * (gi % 4) +: 8];
            end
         end
      end
      for (gi = 0; gi < 4; gi++) begin : g_selword
         assign sel_word[gi] = {sel_reg[4 * gi + 3], sel_reg[4 * gi + 2],
                                sel_reg[4 * gi + 1], sel_reg[4 * gi]};
      end
   endgenerate

   assign line_src[`EEU_LINES-1:`EEU_PIN_LINES] = aux_line_in;

   // ----------------------------------------------------------------
   // one catcher per line
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < `EEU_LINES; gi++) begin : g_line
         eeu_edge_catch u_catch (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .ce         (ce),
            .line_in    (line_src[gi]),
            .rise_en    (rise_reg[gi]),
            .fall_en    (fall_reg[gi]),
            .edge_pulse (edge_hit[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // next values of software registers
   // ----------------------------------------------------------------
   assign imask_next = (reg_wr && imsk_hit) ? reg_wdata[`EEU_LINES-1:0] : imask_reg;
   assign emask_next = (reg_wr && emsk_hit) ? reg_wdata[`EEU_LINES-1:0] : emask_reg;
   assign rise_next  = (reg_wr && rise_hit) ? reg_wdata[`EEU_LINES-1:0] : rise_reg;
   assign fall_next  = (reg_wr && fall_hit) ? reg_wdata[`EEU_LINES-1:0] : fall_reg;

   // ----------------------------------------------------------------
   // pending record and outputs
   // ----------------------------------------------------------------
   // write one to clear; a new edge in the same cycle keeps its bit set
   assign clr_bits     = pend_wr ? reg_wdata[`EEU_LINES-1:0] : `EEU_RST_LINES;
   assign pending_next = (pending_reg & ~clr_bits) | (edge_hit & imask_reg);
   assign irq_next     = |(pending_next & imask_next);
   assign event_out_next = edge_hit & emask_reg;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   eeu_word_t rd_word;
   eeu_word_t line_word;
   eeu_line_t line_pick;

   assign line_pick = imsk_hit ? imask_reg :
                      emsk_hit ? emask_reg :
                      rise_hit ? rise_reg :
                      fall_hit ? fall_reg :
                      pend_hit ? pending_reg : `EEU_RST_LINES;
   assign line_word  = {{(`EEU_DATA_W - `EEU_LINES){1'b0}}, line_pick};
   assign rd_word    = sel_hit ? sel_word[reg_addr[3:2]] : line_word;
   // data stand only in the cycle after the read; unmapped reads give zero
   assign rdata_next = reg_rd ? rd_word : `EEU_RST_WORD;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // ce low freezes every ref_clk register, bus writes included; the line-clocked edge captures still set
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         imask_reg <= `EEU_RST_LINES;
         emask_reg <= `EEU_RST_LINES;
         rise_reg  <= `EEU_RST_LINES;
         fall_reg  <= `EEU_RST_LINES;
      end else if (ce) begin
         imask_reg <= imask_next;
         emask_reg <= emask_next;
         rise_reg  <= rise_next;
         fall_reg  <= fall_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pending_reg   <= `EEU_RST_LINES;
         irq_reg       <= 1'b0;
         event_out_reg <= `EEU_RST_LINES;
         rdata_reg     <= `EEU_RST_WORD;
      end else if (ce) begin
         pending_reg   <= pending_next;
         irq_reg       <= irq_next;
         event_out_reg <= event_out_next;
         rdata_reg     <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq       = irq_reg;
   assign event_out = event_out_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   pend_set_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && |(edge_hit & imask_reg)) |=>
      ((pending_reg & $past(edge_hit & imask_reg)) == $past(edge_hit & imask_reg)))
      else $error("unmasked edge did not set its pending bit");

   masked_quiet_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      ce |=> ((pending_reg & ~$past(pending_reg) & ~$past(imask_reg)) == '0))
      else $error("masked line set a pending bit");

   pend_sticky_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && !pend_wr) |=> ((pending_reg & $past(pending_reg)) == $past(pending_reg)))
      else $error("pending bit dropped without a clear");

   pend_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && pend_wr && !(|edge_hit)) |=>
      ((pending_reg & $past(reg_wdata[`EEU_LINES-1:0])) == '0))
      else $error("write of one did not clear pending");

   irq_level_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      ce |=> (irq == |(pending_reg & imask_reg)))
      else $error("interrupt output disagrees with pending and mask");

   event_gate_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      ce |=> ((event_out & ~$past(emask_reg)) == '0))
      else $error("event pulse on a masked line");

   event_edge_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && |(edge_hit & emask_reg)) |=> (event_out == $past(edge_hit & emask_reg)))
      else $error("event pulse missing after edge");

   sel_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_wr && reg_addr == `EEU_OFF_SEL0) |=>
      (sel_reg[0] == $past(reg_wdata[7:0]) && sel_reg[3] == $past(reg_wdata[31:24])))
      else $error("pin select write not taken");

   read_data_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_rd && pend_hit) |=> (reg_rdata[`EEU_LINES-1:0] == $past(pending_reg)))
      else $error("pending read returned wrong data");

   read_idle_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && !reg_rd) |=> (reg_rdata == '0))
      else $error("read data not zero outside the answer cycle");

   freeze_cfg_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !ce |=> (imask_reg == $past(imask_reg) && emask_reg == $past(emask_reg)))
      else $error("mask registers moved while clock enable was low");

   freeze_trig_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !ce |=> (rise_reg == $past(rise_reg) && fall_reg == $past(fall_reg)))
      else $error("edge choice moved while clock enable was low");

   freeze_pend_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !ce |=> (pending_reg == $past(pending_reg) && irq == $past(irq)))
      else $error("pending record moved while clock enable was low");

   imask_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_wr && imsk_hit) |=> (imask_reg == $past(reg_wdata[`EEU_LINES-1:0])))
      else $error("interrupt mask write not taken");

   emask_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_wr && emsk_hit) |=> (emask_reg == $past(reg_wdata[`EEU_LINES-1:0])))
      else $error("event mask write not taken");

   rise_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_wr && rise_hit) |=> (rise_reg == $past(reg_wdata[`EEU_LINES-1:0])))
      else $error("rising edge choice write not taken");

   fall_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_wr && fall_hit) |=> (fall_reg == $past(reg_wdata[`EEU_LINES-1:0])))
      else $error("falling edge choice write not taken");

   sel_read_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_rd && reg_addr == `EEU_OFF_SEL0) |=> (reg_rdata == $past(sel_word[0])))
      else $error("pin select read returned wrong data");

   route_pin_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (sel_reg[0] < 8'(`EEU_PINS)) |-> (line_src[0] == pin_in[sel_reg[0]]))
      else $error("line does not follow its selected pin");

   park_line_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (sel_reg[3] >= 8'(`EEU_PINS)) |-> !line_src[3])
      else $error("line with out of range select not parked low");

   unmapped_rd_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_rd && !imsk_hit && !emsk_hit && !rise_hit && !fall_hit
       && !pend_hit && !sel_hit) |=> (reg_rdata == '0))
      else $error("unmapped read returned nonzero data");

   upper_zero_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && reg_rd && !sel_hit) |=> (reg_rdata[`EEU_DATA_W-1:`EEU_LINES] == '0))
      else $error("bits above the last line read nonzero");

endmodule

// *** eeu_consts.svh ***
// eeu_consts.svh: offsets, field widths and reset values of the external edge event unit
// assumes: included by bare name from the package and the design files
//
// Overview of operation
// - twenty-three independent edge detector lines, each can raise a request.
// - every detected edge gives an interrupt request and an event request.
// - per line, software picks rising, falling or both edges as trigger.
// - per line interrupt mask and event mask; each blocks only its own request, others keep working.
// - a readable pending bit per line records that a trigger edge happened while the line's interrupt mask bit was set.
// - pulses shorter than one bus clock period must still be caught.
// - any of 168 pins can be routed onto each of the first sixteen lines.
`ifndef EEU_CONSTS_SVH
`define EEU_CONSTS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define EEU_LINES      23
`define EEU_PIN_LINES  16
`define EEU_AUX_LINES  7
`define EEU_PINS       168
`define EEU_SEL_W      8
`define EEU_ADDR_W     8
`define EEU_DATA_W     32

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EEU_OFF_IMSK   8'h00
`define EEU_OFF_EMSK   8'h04
`define EEU_OFF_RISE   8'h08
`define EEU_OFF_FALL   8'h0C
`define EEU_OFF_PEND   8'h10
`define EEU_OFF_SEL0   8'h20
`define EEU_SEL_PAGE   4'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EEU_RST_LINES  23'h000000
`define EEU_RST_SEL    8'h00
`define EEU_RST_WORD   32'h00000000

`endif

// *** eeu_pkg.sv ***
// eeu_pkg.sv: types shared by the external edge event unit files
// assumes: eeu_consts.svh is on the include path
`include "eeu_consts.svh"

package eeu_pkg;
   typedef logic [`EEU_LINES-1:0]     eeu_line_t;
   typedef logic [`EEU_PINS-1:0]      eeu_pins_t;
   typedef logic [`EEU_AUX_LINES-1:0] eeu_aux_t;
   typedef logic [`EEU_SEL_W-1:0]     eeu_sel_t;
   typedef logic [`EEU_ADDR_W-1:0]    eeu_addr_t;
   typedef logic [`EEU_DATA_W-1:0]    eeu_word_t;
endpackage

// *** eeu_edge_catch.sv ***
// eeu_edge_catch.sv: one line's edge catcher, clocked by the line itself
// assumes: clear comes from ref_clk logic; line may glitch while its pin select changes
`timescale 1ns/1ps
`include "eeu_consts.svh"

module eeu_edge_catch (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic line_in,
   input  wire logic rise_en,
   input  wire logic fall_en,
   output logic      edge_pulse
);
   import eeu_pkg::*;

   logic rise_catch;
   logic fall_catch;
   logic rise_s1;
   logic rise_s2;
   logic fall_s1;
   logic fall_s2;
   logic clr_reg;
   logic seen;
   logic fire;

   // ----------------------------------------------------------------
   // capture on the line's own edges
   // ----------------------------------------------------------------
   // a pulse narrower than ref_clk can fall between two samples, so the line clocks these
   always_ff @(posedge line_in or posedge clr_reg) begin
      if (clr_reg) begin
         rise_catch <= 1'b0;
      end else begin
         rise_catch <= 1'b1;
      end
   end

   always_ff @(negedge line_in or posedge clr_reg) begin
      if (clr_reg) begin
         fall_catch <= 1'b0;
      end else begin
         fall_catch <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // two-stage sync and clear handshake
   // ----------------------------------------------------------------
   assign seen = rise_s2 | fall_s2;
   assign fire = ((rise_s2 & rise_en) | (fall_s2 & fall_en)) & ~clr_reg;

   // edges that land while clr_reg is high are lost: three cycles of dead time
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rise_s1    <= 1'b0;
         rise_s2    <= 1'b0;
         fall_s1    <= 1'b0;
         fall_s2    <= 1'b0;
         clr_reg    <= 1'b1;
         edge_pulse <= 1'b0;
      end else if (ce) begin
         rise_s1    <= rise_catch;
         rise_s2    <= rise_s1;
         fall_s1    <= fall_catch;
         fall_s2    <= fall_s1;
         clr_reg    <= seen;
         edge_pulse <= fire;
      end
   end

   clr_handshake_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && seen && !clr_reg) |=> clr_reg)
      else $error("edge catcher did not start its clear");

   edge_enable_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ce && edge_pulse) |-> $past(rise_en || fall_en))
      else $error("edge pulse from a line with no trigger edge chosen");

endmodule

// *** eeu_pin_model.sv ***
// eeu_pin_model.sv: far-side model of the general pins and the auxiliary lines
// assumes: tasks are called just after a rising ref_clk edge
`timescale 1ns/1ps
`include "eeu_consts.svh"

module eeu_pin_model (
   output eeu_pkg::eeu_pins_t pin_in,
   output eeu_pkg::eeu_aux_t  aux_line_in
);
   import eeu_pkg::*;

   initial begin
      pin_in      = '0;
      aux_line_in = '0;
   end

   // ----------------------------------------------------------------
   // line drivers
   // ----------------------------------------------------------------
   // edges land mid-cycle, so they have no phase tie to the bus clock
   task automatic set_line(input int idx, input logic aux, input logic lvl);
      #7;
      if (aux) begin
         aux_line_in[idx] = lvl;
      end else begin
         pin_in[idx] = lvl;
      end
   endtask

   // 4 ns high, far below one clock period: plain sampling would miss it
   task automatic glitch(input int idx);
      #7;
      pin_in[idx] = 1'b1;
      #4;
      pin_in[idx] = 1'b0;
   endtask
endmodule

// *** testbench.sv ***
// testbench.sv: self-checking bench for the external edge event unit
// assumes: eeu_pkg and eeu_pin_model are compiled first
`timescale 1ns/1ps
`include "eeu_consts.svh"

module testbench;
   import eeu_pkg::*;
   logic       ref_clk = 1'b0;
   logic       rst;
   logic       ce;
   logic       reg_wr;
   logic       reg_rd;
   logic       irq;
   eeu_addr_t  reg_addr;
   eeu_word_t  reg_wdata;
   eeu_word_t  reg_rdata;
   eeu_word_t  rd_val;
   eeu_pins_t  pin_in;
   eeu_aux_t   aux_line_in;
   eeu_line_t  event_out;
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         ev_cnt = 0;
   int         ev_base;

   always #10 ref_clk = ~ref_clk;

   // cycles with any event pulse up; a single edge must give exactly one
   always @(posedge ref_clk) begin
      if (event_out !== '0) begin
         ev_cnt <= ev_cnt + 1;
      end
   end

   eeu_external_edge_event_unit i_dut (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .ce          (ce),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .reg_rdata   (reg_rdata),
      .pin_in      (pin_in),
      .aux_line_in (aux_line_in),
      .irq         (irq),
      .event_out   (event_out)
   );

   eeu_pin_model i_pins (
      .pin_in      (pin_in),
      .aux_line_in (aux_line_in)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input eeu_word_t seen, input eeu_word_t exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input eeu_addr_t a, input eeu_word_t d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      // one idle edge, so no strobe is driven twice in one time step
      @(posedge ref_clk);
   endtask

   // data stand only in the cycle after the strobe, then fall back to zero
   task automatic rd(input eeu_addr_t a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      rd_val = reg_rdata;
      @(posedge ref_clk);
      #1;
      check(reg_rdata, '0);
      @(posedge ref_clk);
   endtask

   // one line edge, then pending, irq and event count against expectations
   task automatic hit(input int idx, input logic aux, input logic lvl,
                      input eeu_word_t exp, input int ev);
      ev_base = ev_cnt;
      if (idx < 0) begin
         i_pins.glitch(-idx);
      end else begin
         i_pins.set_line(idx, aux, lvl);
      end
      repeat (10) @(posedge ref_clk);
      check(eeu_word_t'(ev_cnt - ev_base), eeu_word_t'(ev));
      check({31'h0, irq}, {31'h0, exp != '0});
      rd(`EEU_OFF_PEND);
      check(rd_val, exp);
      wr(`EEU_OFF_PEND, exp);
      rd(`EEU_OFF_PEND);
      check(rd_val, '0);
   endtask

   // ----------------------------------------------------------------
   // watchdog: the whole sequence needs well under 2000 cycles
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      close_out();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      static eeu_addr_t offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28,
                                     8'h2C};
      rst       <= 1'b1;
      ce        <= 1'b1;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= '0;
      reg_wdata <= '0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      foreach (offs[i]) begin
         rd(offs[i]);
         check(rd_val, `EEU_RST_WORD);
      end
      check({31'h0, irq}, 32'h00000000);
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40);
      check(rd_val, 32'h00000000);
      wr(`EEU_OFF_IMSK, 32'hFFFFFFFF);
      rd(`EEU_OFF_IMSK);
      check(rd_val, 32'h007FFFFF);
      // line 0 pin 5, line 1 pin 167, line 2 pin 64, line 3 parked, lines 4..14 pin 0
      wr(`EEU_OFF_SEL0, 32'hC840A705);
      wr(8'h2C, 32'h64000000);
      rd(`EEU_OFF_SEL0);
      check(rd_val, 32'hC840A705);
      wr(`EEU_OFF_RISE, 32'h007FFFFD);
      wr(`EEU_OFF_FALL, 32'h00000006);
      wr(`EEU_OFF_IMSK, 32'h007EFFFF);
      wr(`EEU_OFF_EMSK, 32'h007FFFFF);
      // pending survives a zero write and goes only with a one
      i_pins.glitch(5);
      repeat (10) @(posedge ref_clk);
      wr(`EEU_OFF_PEND, 32'h007FFFFE);
      rd(`EEU_OFF_PEND);
      check(rd_val, 32'h00000001);
      wr(`EEU_OFF_PEND, 32'h00000001);
      hit(-5, 1'b0, 1'b1, 32'h00000001, 1);
      hit(167, 1'b0, 1'b1, 32'h00000000, 0);
      hit(167, 1'b0, 1'b0, 32'h00000002, 1);
      hit(64, 1'b0, 1'b1, 32'h00000004, 1);
      hit(64, 1'b0, 1'b0, 32'h00000004, 1);
      hit(0, 1'b0, 1'b1, 32'h00007FF0, 1);
      hit(0, 1'b0, 1'b0, 32'h00000000, 0);
      hit(-100, 1'b0, 1'b1, 32'h00008000, 1);
      hit(0, 1'b1, 1'b1, 32'h00000000, 1);
      hit(1, 1'b1, 1'b1, 32'h00020000, 1);
      // masking hides a pending line from irq without clearing it
      i_pins.set_line(6, 1'b1, 1'b1);
      repeat (10) @(posedge ref_clk);
      check({31'h0, irq}, 32'h00000001);
      wr(`EEU_OFF_IMSK, 32'h00000000);
      repeat (2) @(posedge ref_clk);
      check({31'h0, irq}, 32'h00000000);
      rd(`EEU_OFF_PEND);
      check(rd_val, 32'h00400000);
      // a write while clock enable is low is lost
      ce <= 1'b0;
      wr(`EEU_OFF_IMSK, 32'h007FFFFF);
      ce <= 1'b1;
      rd(`EEU_OFF_IMSK);
      check(rd_val, 32'h00000000);
      close_out();
   end
endmodule
